// ==== rtl/bls_pkg.sv ====
/*
  Constants, field layouts and carrier types for the load-switch and
  buck-1 configuration register bank.
  Assumes a single 125 MHz clock and a synchronous active-high reset.
*/
package bls_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_LOAD_SWITCH_CONFIG = 8'h15;
  localparam logic [7:0] ADDR_BUCK1_CONTROL      = 8'h16;

  // Load-switch register fields
  localparam int         LS_POWERFAIL_CUTOFF_BIT = 5;
  localparam int         LS_DISCHARGE_EN_BIT     = 2;
  localparam int         LS_WRITABLE_MSB         = 5;
  localparam logic [5:0] LS_CONFIG_RESET         = 6'h00;

  // Buck-1 register fields
  localparam int         PULSE_SKIP_BIT          = 7;
  localparam logic       PULSE_SKIP_RESET        = 1'b1;
  localparam logic [5:0] VCODE_RESET             = 6'h19;
  localparam logic [7:0] BUCK1_CONTROL_RESET     = 8'h99;
  localparam logic [7:0] RD_UNMAPPED             = 8'h00;

  // Voltage code mapping in millivolts
  localparam logic [5:0]  VCODE_KNEE             = 6'h32;
  localparam logic [10:0] VOUT_BASE_MV           = 11'h352;
  localparam logic [10:0] VOUT_KNEE_MV           = 11'h546;
  localparam logic [10:0] VOUT_FINE_STEP_MV      = 11'h00a;
  localparam logic [10:0] VOUT_COARSE_STEP_MV    = 11'h019;
  localparam logic [10:0] VOUT_RESET_MV          = 11'h44c;

  // Monitor blanking time
  localparam int          CLK_MHZ                = 125;
  localparam int          BLANK_TIME_US          = 5000;
  localparam int          BLANK_CYCLES           = BLANK_TIME_US * CLK_MHZ;
  localparam int          BLANK_CNT_W            = 20;

  // Register-bank state
  typedef struct packed {
    logic [5:0]  ls_cfg;
    logic        pulse_skip;
    logic [5:0]  vcode;
    logic [5:0]  vcode_applied;
    logic [10:0] target_mv;
    logic [7:0]  rd_data;
    logic        rd_valid;
    logic        wr_refused;
    logic        ls_on;
    logic        ls_discharge;
    logic        pfo_n;
  } bls_state_t;

  // Blanking timer state
  typedef struct packed {
    logic                   active;
    logic [BLANK_CNT_W-1:0] cnt;
  } bls_timer_t;

  // Map a voltage code to its target in millivolts
  function automatic logic [10:0] bls_code_to_mv(input logic [5:0] code);
    logic [10:0] c;
    c = {5'h00, code};
    if (code <= VCODE_KNEE)
      return 11'(VOUT_BASE_MV + c * VOUT_FINE_STEP_MV);
    else
      return 11'(VOUT_KNEE_MV + (c - {5'h00, VCODE_KNEE}) * VOUT_COARSE_STEP_MV);
  endfunction

endpackage

// ==== rtl/bls_blank_timer.sv ====
/*
  Retriggerable one-shot that holds the voltage-monitor blanking window.
  Assumes i_start is a one-cycle pulse and P_CYCLES is at least one.
*/
`timescale 1ns/1ns
module bls_blank_timer
  import bls_pkg::*;
#(
  parameter int unsigned P_CYCLES = BLANK_CYCLES
)
(
  // Clock and reset
  input  wire logic i_mclk,
  input  wire logic i_reset,
  // Control
  input  wire logic i_start,
  // Status
  output logic      o_active
);

  bls_timer_t st;
  bls_timer_t next_st;

  // Restart wins over the running count so back-to-back writes extend the window
  always_comb
  begin
    next_st = st;
    if (i_start)
    begin
      next_st.active = 1'b1;
      next_st.cnt    = BLANK_CNT_W'(P_CYCLES - 1);
    end
    else if (st.active)
    begin
      if (st.cnt == '0)
        next_st.active = 1'b0;
      else
        next_st.cnt = st.cnt - 1'b1;
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
      st <= '0;
    else
      st <= next_st;
  end

  assign o_active = st.active;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);

  AST_BLANK_ENDS: assert property (st.active && st.cnt == '0 && !i_start |=> !st.active)
    else $error("blanking window did not close at terminal count");
  AST_BLANK_RELOAD: assert property (
      i_start |=> st.active && st.cnt == BLANK_CNT_W'(P_CYCLES - 1))
    else $error("blanking window not reloaded on start");

endmodule // bls_blank_timer

// ==== rtl/bls_regs.sv ====
/*
  Load-switch and buck-1 configuration registers with the switch, discharge,
  power-fail and voltage-apply logic they steer.
  Assumes the management-bus slave decodes transfers into one-cycle read and
  write strobes, and that the password logic and the apply register elsewhere
  supply i_unlocked and i_apply_strobe.
*/
`timescale 1ns/1ns
module bls_regs
  import bls_pkg::*;
#(
  parameter int unsigned P_BLANK_CYCLES = BLANK_CYCLES
)
(
  // Clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_reset,
  // Register access from the bus slave
  input  wire logic        i_wr_en,
  input  wire logic        i_rd_en,
  input  wire logic [7:0]  i_addr,
  input  wire logic [7:0]  i_wr_data,
  output logic      [7:0]  o_rd_data,
  output logic             o_rd_valid,
  output logic             o_wr_refused,
  // Neighbouring control
  input  wire logic        i_unlocked,
  input  wire logic        i_apply_strobe,
  input  wire logic        i_ls_enable,
  input  wire logic        i_pf_trip,
  // Load switch
  output logic             o_ls_on,
  output logic             o_ls_discharge,
  output logic             o_power_fail_out_n,
  // Buck 1
  output logic             o_pulse_skip_enable,
  output logic      [5:0]  o_buck1_vcode,
  output logic      [10:0] o_buck1_target_mv,
  output logic             o_monitor_blank
);

  bls_state_t st;
  bls_state_t next_st;
  logic       wr_ls;
  logic       wr_buck;
  logic       ls_on_nx;

  // Accepted writes only; locked writes leave no trace beyond the refusal pulse
  assign wr_ls   = i_wr_en && i_unlocked && (i_addr == ADDR_LOAD_SWITCH_CONFIG);
  assign wr_buck = i_wr_en && i_unlocked && (i_addr == ADDR_BUCK1_CONTROL);

  // Cutoff only gates the switch; the enable itself lives in another register
  assign ls_on_nx = i_ls_enable &&
                    !(st.ls_cfg[LS_POWERFAIL_CUTOFF_BIT] && i_pf_trip);

  // Register file and derived outputs
  always_comb
  begin
    next_st            = st;
    next_st.rd_valid   = i_rd_en;
    next_st.wr_refused = i_wr_en && !i_unlocked &&
                         (i_addr == ADDR_LOAD_SWITCH_CONFIG || i_addr == ADDR_BUCK1_CONTROL);
    if (wr_ls)
      next_st.ls_cfg = i_wr_data[LS_WRITABLE_MSB:0];
    if (wr_buck)
    begin
      next_st.pulse_skip = i_wr_data[PULSE_SKIP_BIT];
      next_st.vcode      = i_wr_data[5:0];
    end
    // Apply takes the code held before any same-cycle write
    if (i_apply_strobe)
    begin
      next_st.vcode_applied = st.vcode;
      next_st.target_mv     = bls_code_to_mv(st.vcode);
    end
    if (i_rd_en)
    begin
      unique case (i_addr)
        ADDR_LOAD_SWITCH_CONFIG: next_st.rd_data = {2'b00, st.ls_cfg};
        ADDR_BUCK1_CONTROL:      next_st.rd_data = {st.pulse_skip, 1'b0, st.vcode};
        default:                 next_st.rd_data = RD_UNMAPPED;
      endcase
    end
    next_st.ls_on        = ls_on_nx;
    next_st.ls_discharge = st.ls_cfg[LS_DISCHARGE_EN_BIT] && !ls_on_nx;
    next_st.pfo_n        = !i_pf_trip;
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
    begin
      st               <= '0;
      st.ls_cfg        <= LS_CONFIG_RESET;
      st.pulse_skip    <= PULSE_SKIP_RESET;
      st.vcode         <= VCODE_RESET;
      st.vcode_applied <= VCODE_RESET;
      st.target_mv     <= VOUT_RESET_MV;
      st.pfo_n         <= 1'b1;
    end
    else
      st <= next_st;
  end

  // Every accepted buck-1 write restarts the monitor blanking window
  bls_blank_timer #(
    .P_CYCLES (P_BLANK_CYCLES)
  ) u_blank (
    .i_mclk   (i_mclk),
    .i_reset  (i_reset),
    .i_start  (wr_buck),
    .o_active (o_monitor_blank)
  );

  // Outputs straight from state
  assign o_rd_data           = st.rd_data;
  assign o_rd_valid          = st.rd_valid;
  assign o_wr_refused        = st.wr_refused;
  assign o_ls_on             = st.ls_on;
  assign o_ls_discharge      = st.ls_discharge;
  assign o_power_fail_out_n  = st.pfo_n;
  assign o_pulse_skip_enable = st.pulse_skip;
  assign o_buck1_vcode       = st.vcode_applied;
  assign o_buck1_target_mv   = st.target_mv;

  // Checks run on the system clock and pause while reset is held
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);

  // Write gating: a locked write changes nothing and only raises the refusal pulse, and only at 15h or 16h
  AST_LOCKED_IGNORED: assert property (
      i_wr_en && !i_unlocked
      |=> $stable(st.ls_cfg) && $stable(st.vcode) && $stable(st.pulse_skip) &&
          o_wr_refused == ($past(i_addr) == ADDR_LOAD_SWITCH_CONFIG ||
                           $past(i_addr) == ADDR_BUCK1_CONTROL))
    else $error("locked write changed a register");

  AST_REFUSED_UNLOCKED: assert property (
      i_unlocked |=> !o_wr_refused)
    else $error("write refused while unlocked");

  AST_LOCKED_NO_BLANK: assert property (
      i_wr_en && !i_unlocked && !o_monitor_blank |=> !o_monitor_blank)
    else $error("locked write started monitor blanking");

  AST_LS_HOLD: assert property (
      !wr_ls |=> $stable(st.ls_cfg))
    else $error("load-switch register moved without accepted write");

  AST_BUCK_HOLD: assert property (
      !wr_buck |=> $stable(st.vcode) && $stable(st.pulse_skip))
    else $error("buck-1 register moved without accepted write");

  // Load switch, discharge and power-fail output
  AST_CUTOFF: assert property (
      st.ls_cfg[LS_POWERFAIL_CUTOFF_BIT] && i_pf_trip |=> !o_ls_on && !o_power_fail_out_n)
    else $error("switch stayed on after power-fail trip");

  AST_NO_CUTOFF: assert property (
      !st.ls_cfg[LS_POWERFAIL_CUTOFF_BIT] && i_ls_enable |=> o_ls_on)
    else $error("comparator affected switch with cutoff off");

  AST_DISCHARGE: assert property (
      o_ls_discharge |-> !o_ls_on && $past(st.ls_cfg[LS_DISCHARGE_EN_BIT]))
    else $error("discharge while switch on or disabled");

  AST_DISCHARGE_ON: assert property (
      st.ls_cfg[LS_DISCHARGE_EN_BIT] && !ls_on_nx |=> o_ls_discharge)
    else $error("no discharge with switch off and discharge enabled");

  AST_PFO_LOW: assert property (
      i_pf_trip |=> !o_power_fail_out_n)
    else $error("fail output not low after comparator trip");

  // Register contents, read-back and reset values
  AST_WRITE_LS: assert property (
      wr_ls |=> {2'b00, st.ls_cfg} == ($past(i_wr_data) & 8'h3f))
    else $error("load-switch write not stored");

  AST_WRITE_BUCK: assert property (
      wr_buck |=> {st.pulse_skip, 1'b0, st.vcode} == ($past(i_wr_data) & 8'hbf))
    else $error("buck-1 write not stored");

  AST_READ_BUCK: assert property (
      i_rd_en && i_addr == ADDR_BUCK1_CONTROL
      |=> o_rd_valid && o_rd_data == {$past(st.pulse_skip), 1'b0, $past(st.vcode)})
    else $error("buck-1 read data wrong");

  AST_READ_LS_TOP: assert property (
      o_rd_valid && $past(i_addr) == ADDR_LOAD_SWITCH_CONFIG |-> o_rd_data[7:6] == 2'b00)
    else $error("load-switch reserved bits read nonzero");

  AST_RESET_VALUE: assert property (
      $past(i_reset)
      |-> {st.pulse_skip, 1'b0, st.vcode} == BUCK1_CONTROL_RESET &&
          st.ls_cfg == LS_CONFIG_RESET)
    else $error("wrong reset value");

  // Blanking window and voltage apply
  AST_BLANK_AFTER_WRITE: assert property (
      wr_buck |=> o_monitor_blank [*8])
    else $error("monitoring not blanked after buck-1 write");

  AST_APPLY: assert property (
      i_apply_strobe |=> o_buck1_vcode == $past(st.vcode))
    else $error("apply strobe did not take new code");

  AST_HOLD: assert property (
      !i_apply_strobe |=> $stable(o_buck1_vcode) && $stable(o_buck1_target_mv))
    else $error("voltage target moved without apply");

  AST_TARGET_MV: assert property (
      o_buck1_vcode == 6'h3f |-> o_buck1_target_mv == 11'h68b)
    else $error("top code not at 1675 mV");

  AST_TARGET_KNEE: assert property (
      o_buck1_vcode == VCODE_KNEE |-> o_buck1_target_mv == VOUT_KNEE_MV)
    else $error("knee code not at 1350 mV");

  // Main scenarios worth seeing at least once
  COV_CUTOFF: cover property (
      st.ls_cfg[LS_POWERFAIL_CUTOFF_BIT] && i_ls_enable && i_pf_trip ##1 !o_ls_on);
  COV_WRITE_APPLY: cover property (wr_buck ##[1:20] i_apply_strobe);
  COV_REFUSED: cover property (o_wr_refused);
  COV_DISCHARGE: cover property (o_ls_discharge);
  COV_APPLY_TOP: cover property (i_apply_strobe ##1 o_buck1_vcode == 6'h3f);

endmodule // bls_regs

// ==== tb/bls_host_ctrl.sv ====
/*
  Host-side control model: password unlock state and voltage apply strobe.
  Assumes bench requests change just after the rising clock edge.
*/
`timescale 1ns/1ns
module bls_host_ctrl
#(
  parameter logic [7:0] P_KEY = 8'h5a  // Arbitrary unlock key
)
(
  // Clock and reset
  input  wire logic       i_mclk,
  input  wire logic       i_reset,
  // Requests from the bench
  input  wire logic [7:0] i_key,
  input  wire logic       i_key_valid,
  input  wire logic       i_go,
  // Controls towards the registers
  output logic            o_unlocked,
  output logic            o_apply_strobe
);
  // A wrong key locks again, so stale unlocks cannot linger
  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
    begin
      o_unlocked     <= 1'b0;
      o_apply_strobe <= 1'b0;
    end
    else
    begin
      if (i_key_valid)
        o_unlocked <= (i_key == P_KEY);
      o_apply_strobe <= i_go;
    end
  end
endmodule // bls_host_ctrl

// ==== tb/bls_regs_bench.sv ====
/*
  Self-checking bench for the buck-1 and load-switch register bank.
  Assumes the host control model is compiled before this file.
*/
`timescale 1ns/1ns
module bls_regs_bench;
  import bls_pkg::*;
  localparam int P_BLANK = 10;
  logic        i_mclk, i_reset, i_wr_en, i_rd_en, i_ls_enable, i_pf_trip;
  logic [7:0]  i_addr, i_wr_data, o_rd_data, key, cfg;
  logic        key_valid, go, i_unlocked, i_apply_strobe, o_rd_valid, o_wr_refused;
  logic        o_ls_on, o_ls_discharge, o_power_fail_out_n, o_pulse_skip_enable;
  logic [5:0]  o_buck1_vcode;
  logic [10:0] o_buck1_target_mv;
  logic        o_monitor_blank, on;
  logic [31:0] seed;
  int          n_fail, tests_run, cycles, m_ls, m_ps, m_code, m_app;
  bls_regs #(.P_BLANK_CYCLES(P_BLANK)) DUT (.i_mclk, .i_reset, .i_wr_en, .i_rd_en,
    .i_addr, .i_wr_data, .o_rd_data, .o_rd_valid, .o_wr_refused, .i_unlocked,
    .i_apply_strobe, .i_ls_enable, .i_pf_trip, .o_ls_on, .o_ls_discharge,
    .o_power_fail_out_n, .o_pulse_skip_enable, .o_buck1_vcode, .o_buck1_target_mv,
    .o_monitor_blank);
  bls_host_ctrl HOST (.i_mclk, .i_reset, .i_key(key), .i_key_valid(key_valid),
    .i_go(go), .o_unlocked(i_unlocked), .o_apply_strobe(i_apply_strobe));
  // Free-running 125 MHz clock
  initial
  begin
    i_mclk = 1'b0;
    forever #4 i_mclk = ~i_mclk;
  end
  // Hang guard, far above the expected run of about 155 cycles
  always @(posedge i_mclk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_fail++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    if (n_fail == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // Model target: fine steps up to the knee, coarse steps above
  function automatic logic [15:0] mv(input int c);
    return 16'(c <= 50 ? 850 + 10 * c : 1350 + 25 * (c - 50));
  endfunction
  task automatic pulse(input logic [7:0] a, input logic [7:0] d, input bit w);
    @(posedge i_mclk);
    #1;
    i_addr = a;
    i_wr_data = d;
    i_wr_en = w;
    i_rd_en = !w;
    @(posedge i_mclk);
    #1;
    i_wr_en = 1'b0;
    i_rd_en = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    pulse(a, 8'h00, 1'b0);
    chk(o_rd_valid, 1'b1);
    chk(o_rd_data, e);
  endtask
  // Write plus model update; refusal only for locked 15h/16h writes
  task automatic mwr(input logic [7:0] a, input logic [7:0] d);
    pulse(a, d, 1'b1);
    chk(o_wr_refused, !i_unlocked && (a == 8'h15 || a == 8'h16));
    if (!i_unlocked)
      chk(o_monitor_blank, 1'b0);
    if (i_unlocked && a == 8'h15)
      m_ls = d & 8'h3f;
    if (i_unlocked && a == 8'h16)
    begin
      m_ps = d[7];
      m_code = d & 8'h3f;
      chk(o_monitor_blank, 1'b1);
      chk(o_pulse_skip_enable, m_ps[0]);
      chk(o_buck1_vcode, m_app);
    end
  endtask
  task automatic step(input logic [7:0] k, input bit v, input bit g);
    @(posedge i_mclk);
    #1;
    key = k;
    key_valid = v;
    go = g;
    @(posedge i_mclk);
    #1;
    key_valid = 1'b0;
    go = 1'b0;
  endtask
  initial
  begin
    {i_wr_en, i_rd_en, i_ls_enable, i_pf_trip, key_valid, go} = '0;
    {i_addr, i_wr_data, key} = '0;
    {m_ls, m_ps, m_code, m_app, seed} = {32'd0, 32'd1, 32'h19, 32'h19, 32'd81189};
    i_reset = 1'b1;
    repeat (3) @(posedge i_mclk);
    #1;
    i_reset = 1'b0;
    chk(o_buck1_target_mv, 16'd1100);
    rd(8'h15, 8'h00);
    rd(8'h16, 8'h99);
    rd(8'h20, 8'h00);
    mwr(8'h16, 8'h05);
    rd(8'h16, 8'h99);
    step(8'h5a, 1'b1, 1'b0);
    mwr(8'h15, 8'hff);
    rd(8'h15, 8'h3f);
    // Knee codes both sides, both ends, then random codes
    for (int i = 0; i < 6; i++)
    begin
      seed = xs(seed);
      cfg = i < 4 ? {seed[7:6], 6'(i == 0 ? 0 : i == 1 ? 50 : i == 2 ? 51 : 63)} : seed[7:0];
      mwr(8'h16, cfg);
      rd(8'h16, 8'(m_ps * 128 + m_code));
      repeat (P_BLANK - 3) @(posedge i_mclk);
      #1;
      chk(o_monitor_blank, 1'b1);
      @(posedge i_mclk);
      #1;
      chk(o_monitor_blank, 1'b0);
      step(8'h00, 1'b0, 1'b1);
      @(posedge i_mclk);
      #1;
      m_app = m_code;
      chk(o_buck1_vcode, m_app);
      chk(o_buck1_target_mv, mv(m_app));
    end
    // Cutoff and discharge bits against every enable and trip pair
    for (int c = 0; c < 4; c++)
    begin
      mwr(8'h15, {2'b00, c[1], 2'b00, c[0], 2'b00});
      for (int k = 0; k < 4; k++)
      begin
        i_ls_enable = k[0];
        i_pf_trip = k[1];
        repeat (2) @(posedge i_mclk);
        #1;
        on = k[0] && !(c[1] && k[1]);
        chk(o_ls_on, on);
        chk(o_ls_discharge, c[0] && !on);
        chk(o_power_fail_out_n, !k[1]);
      end
    end
    step(8'h11, 1'b1, 1'b0);
    mwr(8'h15, 8'h3f);
    rd(8'h15, 8'(m_ls));
    end_of_test();
  end
endmodule // bls_regs_bench
